/* hdl/ids_map.vh */
// constants of the direction and acknowledge status block
// assumes a 4-bit register byte address and 8-bit registers in low lanes
`ifndef IDS_MAP_VH
`define IDS_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define IDS_CTRL_ADDR 4'h0
`define IDS_STAT_ADDR 4'h4

// ----------------------------------------------------------------
// bus control register fields
// ----------------------------------------------------------------
`define IDS_CTRL_ENA_BIT 7
`define IDS_CTRL_EXIT_BIT 6
`define IDS_CTRL_WCAN_BIT 5
`define IDS_CTRL_RST 1'h0

// ----------------------------------------------------------------
// bus status register fields
// ----------------------------------------------------------------
`define IDS_STAT_DIR_BIT 3
`define IDS_STAT_ACK_BIT 2
`define IDS_DIR_RST 1'h0
`define IDS_ACK_RST 1'h0

// ----------------------------------------------------------------
// bit clock positions within a byte
// ----------------------------------------------------------------
`define IDS_LSB_CLK 4'h8
`define IDS_ACK_CLK 4'h9
`define IDS_FIRST_CLK 4'h1
`define IDS_CNT_RST 4'h0

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define IDS_RESP_OKAY 2'h0
`define IDS_RESP_SLVERR 2'h2

`endif

/* hdl/ids_sync.v */
// two flip-flop synchroniser, one stage pair per bit
// assumes inputs are asynchronous to clk_in
module ids_sync #(
  parameter WIDTH = 2
) (
  // clock, reset, enable
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  // data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge clk_in) begin
        if (!nrst_in) begin
          meta_ff <= 1'h1;
          sync_ff <= 1'h1;
        end else if (ce_in) begin
          meta_ff <= async_in[i];
          sync_ff <= meta_ff;
        end
      end
      assign sync_out[i] = sync_ff;
    end
  endgenerate

endmodule // ids_sync

/* hdl/ids_top.v */
// direction flag and acknowledge-detected flag of a two-wire bus unit
// assumes start generation, role and arbitration loss come from the
// rest of the unit on clk_in; the bus lines are asynchronous pins
`include "ids_map.vh"

module ids_top #(
  parameter ADDR_W = 4
) (
  // clock, reset, enable
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  // axi4-lite write address
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [ADDR_W-1:0] s_axi_awaddr_in,
  // axi4-lite write data
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  output wire [1:0] s_axi_bresp_out,
  // axi4-lite read address
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  input wire [ADDR_W-1:0] s_axi_araddr_in,
  // axi4-lite read data
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  // rest of the unit
  input wire master_role_in,
  input wire start_generated_in,
  input wire arbitration_loss_flag_in,
  input wire serial_output_latch_in,
  // bus pins
  input wire serial_clock_line_in,
  input wire serial_data_line_in,
  output wire serial_data_line_out,
  output wire serial_data_line_oe_out,
  // status
  output wire direction_flag_out,
  output wire ack_detected_flag_out,
  output wire operation_enable_out
);

  // ----------------------------------------------------------------
  // pin synchronisation and bus event detection
  // ----------------------------------------------------------------
  wire [1:0] line_sync;
  reg scl_d_ff;
  reg sda_d_ff;
  wire scl_s;
  wire sda_s;

  ids_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .async_in({serial_clock_line_in, serial_data_line_in}),
    .sync_out(line_sync)
  );

  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      scl_d_ff <= 1'h1;
      sda_d_ff <= 1'h1;
    end else if (ce_in) begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ----------------------------------------------------------------
  // bit counter
  // ----------------------------------------------------------------
  // counter only runs between a start and a stop; a glitch on the
  // clock line outside a frame therefore cannot fake a ninth clock
  reg [3:0] bit_cnt_ff;
  reg first_byte_ff;
  reg active_ff;

  wire next_byte_clk = scl_rise & active_ff & (bit_cnt_ff == `IDS_ACK_CLK);
  wire lsb_clk = scl_rise & active_ff & first_byte_ff &
                 (bit_cnt_ff == (`IDS_LSB_CLK - `IDS_FIRST_CLK));
  wire ack_clk = scl_rise & active_ff &
                 (bit_cnt_ff == (`IDS_ACK_CLK - `IDS_FIRST_CLK));
  wire ninth_fall = scl_fall & active_ff & first_byte_ff &
                    (bit_cnt_ff == `IDS_ACK_CLK);

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      bit_cnt_ff <= `IDS_CNT_RST;
      first_byte_ff <= 1'h0;
      active_ff <= 1'h0;
    end else if (ce_in) begin
      if (start_det) begin
        bit_cnt_ff <= `IDS_CNT_RST;
        first_byte_ff <= 1'h1;
        active_ff <= 1'h1;
      end else if (stop_det) begin
        bit_cnt_ff <= `IDS_CNT_RST;
        first_byte_ff <= 1'h0;
        active_ff <= 1'h0;
      end else if (next_byte_clk) begin
        bit_cnt_ff <= `IDS_FIRST_CLK;
        first_byte_ff <= 1'h0;
      end else if (scl_rise & active_ff) begin
        bit_cnt_ff <= bit_cnt_ff + `IDS_FIRST_CLK;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  reg aw_got_ff;
  reg w_got_ff;
  reg [ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg ctrl_en_ff;
  reg exit_req_ff;
  reg wait_cancel_ff;
  reg en_d_ff;
  reg dir_ff;
  reg ack_ff;

  assign s_axi_awready_out = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready_out = ~w_got_ff & ~bvalid_ff;
  assign s_axi_arready_out = ~rvalid_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;

  wire aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire w_take = s_axi_wvalid_in & s_axi_wready_out;
  wire ar_take = s_axi_arvalid_in & s_axi_arready_out;
  wire wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_ctrl = wr_go & (awaddr_ff == `IDS_CTRL_ADDR);
  wire wr_stat = wr_go & (awaddr_ff == `IDS_STAT_ADDR);
  wire ctrl_lane = wr_ctrl & wstrb_ff[0];

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      aw_got_ff <= 1'h0;
      w_got_ff <= 1'h0;
      awaddr_ff <= {ADDR_W{1'h0}};
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'h0;
      bresp_ff <= `IDS_RESP_OKAY;
    end else if (ce_in) begin
      if (aw_take) begin
        aw_got_ff <= 1'h1;
        awaddr_ff <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_got_ff <= 1'h1;
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_got_ff <= 1'h0;
        w_got_ff <= 1'h0;
        bvalid_ff <= 1'h1;
        bresp_ff <= (wr_ctrl | wr_stat) ? `IDS_RESP_OKAY :
                    `IDS_RESP_SLVERR;
      end else if (bvalid_ff & s_axi_bready_in) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl_en_ff <= `IDS_CTRL_RST;
      exit_req_ff <= 1'h0;
      wait_cancel_ff <= 1'h0;
      en_d_ff <= `IDS_CTRL_RST;
    end else if (ce_in) begin
      en_d_ff <= ctrl_en_ff;
      exit_req_ff <= ctrl_lane & wdata_ff[`IDS_CTRL_EXIT_BIT];
      wait_cancel_ff <= ctrl_lane & wdata_ff[`IDS_CTRL_WCAN_BIT];
      if (ctrl_lane) begin
        ctrl_en_ff <= wdata_ff[`IDS_CTRL_ENA_BIT];
      end
    end
  end

  // status writes are accepted and ignored: the register is read-only
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      rvalid_ff <= 1'h0;
      rdata_ff <= 32'h0;
      rresp_ff <= `IDS_RESP_OKAY;
    end else if (ce_in) begin
      if (ar_take) begin
        rvalid_ff <= 1'h1;
        rdata_ff <= 32'h0;
        rresp_ff <= `IDS_RESP_OKAY;
        if (s_axi_araddr_in == `IDS_CTRL_ADDR) begin
          rdata_ff[`IDS_CTRL_ENA_BIT] <= ctrl_en_ff;
        end else if (s_axi_araddr_in == `IDS_STAT_ADDR) begin
          rdata_ff[`IDS_STAT_DIR_BIT] <= dir_ff;
          rdata_ff[`IDS_STAT_ACK_BIT] <= ack_ff;
        end else begin
          rresp_ff <= `IDS_RESP_SLVERR;
        end
      end else if (rvalid_ff & s_axi_rready_in) begin
        rvalid_ff <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // direction flag
  // ----------------------------------------------------------------
  reg arb_d_ff;
  wire arb_rise = arbitration_loss_flag_in & ~arb_d_ff;
  wire en_fall = en_d_ff & ~ctrl_en_ff;
  reg dir_set;
  reg dir_clr;

  always @* begin
    dir_set = 1'h0;
    dir_clr = 1'h0;
    if (master_role_in) begin
      dir_set = start_generated_in | (lsb_clk & ~sda_s);
      dir_clr = lsb_clk & sda_s;
    end else begin
      dir_set = lsb_clk & sda_s;
      dir_clr = start_det | (lsb_clk & ~sda_s);
    end
    dir_clr = dir_clr | stop_det | exit_req_ff | en_fall |
              wait_cancel_ff | arb_rise;
  end

  // a bus event that sets the flag wins over a clear in the same cycle
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      dir_ff <= `IDS_DIR_RST;
      arb_d_ff <= 1'h0;
    end else if (ce_in) begin
      arb_d_ff <= arbitration_loss_flag_in;
      if (dir_set) begin
        dir_ff <= 1'h1;
      end else if (dir_clr) begin
        dir_ff <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  // open drain: only a low level is driven, a high is a released line
  reg drive_ok_ff;
  reg sda_oe_ff;
  reg sda_o_ff;

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      drive_ok_ff <= 1'h0;
      sda_oe_ff <= 1'h0;
      sda_o_ff <= 1'h0;
    end else if (ce_in) begin
      if (~dir_ff | wait_cancel_ff | dir_clr) begin
        drive_ok_ff <= 1'h0;
      end else if (ninth_fall) begin
        drive_ok_ff <= 1'h1;
      end
      sda_oe_ff <= dir_ff & drive_ok_ff & ~dir_clr &
                   ~serial_output_latch_in;
      sda_o_ff <= 1'h0;
    end
  end

  assign serial_data_line_out = sda_o_ff;
  assign serial_data_line_oe_out = sda_oe_ff;

  // ----------------------------------------------------------------
  // acknowledge-detected flag
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      ack_ff <= `IDS_ACK_RST;
    end else if (ce_in) begin
      if (ack_clk & ~sda_s) begin
        ack_ff <= 1'h1;
      end else if (stop_det | next_byte_clk | exit_req_ff | en_fall |
                   ack_clk) begin
        ack_ff <= 1'h0;
      end
    end
  end

  assign direction_flag_out = dir_ff;
  assign ack_detected_flag_out = ack_ff;
  assign operation_enable_out = ctrl_en_ff;

endmodule // ids_top

/* verif/ids_checker.sv */
// assertions on the pins and flags of the status block
// assumes the unit side driven on clk_in; frozen cycles are not checked
module ids_chk (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // unit side
  input wire logic master_role_in,
  input wire logic start_generated_in,
  input wire logic arbitration_loss_flag_in,
  // bus pins
  input wire logic serial_clock_line_in,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe_out,
  // status
  input wire logic direction_flag_out,
  input wire logic ack_detected_flag_out,
  input wire logic operation_enable_out
);
  timeunit 1ns;
  timeprecision 10ps;
  default clocking cb @(posedge clk_in); endclocking
  // a low enable freezes the block, so timing windows do not apply
  default disable iff (!nrst_in || !ce_in);
  // oe is registered, so it may trail a clear by one cycle
  a_recv_released: assert property (
    !direction_flag_out && !$past(direction_flag_out)
      |-> !serial_data_line_oe_out) else $error("line driven in receive");
  a_drive_low: assert property (
    serial_data_line_oe_out |-> !serial_data_line_out)
    else $error("open drain drives high");
  a_drive_late: assert property (
    $rose(serial_data_line_oe_out) |-> !serial_clock_line_in)
    else $error("drive began while clock high");
  a_start_sets: assert property (
    master_role_in && start_generated_in |-> ##[1:2] direction_flag_out)
    else $error("start did not set direction");
  a_arb_clears: assert property (
    $rose(arbitration_loss_flag_in) |-> ##[1:2] !direction_flag_out)
    else $error("arbitration loss kept direction");
  a_off_clears: assert property (
    $fell(operation_enable_out) |-> ##[0:2]
      (!direction_flag_out && !ack_detected_flag_out))
    else $error("disable kept flags");
  a_ack_on_low: assert property (
    $rose(ack_detected_flag_out) |->
      serial_clock_line_in && !serial_data_line_in)
    else $error("ack set without low data");
  a_stop_clears: assert property (
    serial_clock_line_in && $rose(serial_data_line_in) |-> ##[3:8]
      (!direction_flag_out && !ack_detected_flag_out))
    else $error("stop kept flags");
endmodule // ids_chk

bind ids_top ids_chk u_chk (.*);

/* verif/ids_bus_peer.sv */
// far-side party on the two-wire bus, behavioural, 125 ns bit clock
// assumes the bench resolves the open-drain data line with a pull-up
module ids_bus_peer (
  // bus lines
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 10ps;
  // clock stands high and data is released outside frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic bit_out(input logic b);
    #31.25 sda_low_out = !b;
    #31.25 scl_out = 1'b1;
    #62.5 scl_out = 1'b0;
  endtask
  // also serves as a repeated start from a low clock
  task automatic start_cond();
    #31.25 sda_low_out = 1'b0;
    #31.25 scl_out = 1'b1;
    #31.25 sda_low_out = 1'b1;
    #31.25 scl_out = 1'b0;
  endtask
  task automatic stop_cond();
    #31.25 sda_low_out = 1'b1;
    #31.25 scl_out = 1'b1;
    #31.25 sda_low_out = 1'b0;
  endtask
  // msb first, ninth clock acknowledged when ack is 1, then released
  task automatic byte_out(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_out(!ack);
    #31.25 sda_low_out = 1'b0;
  endtask
endmodule // ids_bus_peer

/* verif/testbench.sv */
// register and bus scenarios for the status block
// assumes the peer model plays the far side of the two-wire bus
`include "ids_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 10ps;
  logic clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_bready_in = 1'b1;
  logic s_axi_rready_in = 1'b1;
  logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic master_role_in = 1'b0, start_generated_in = 1'b0;
  logic arbitration_loss_flag_in = 1'b0, serial_output_latch_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, serial_data_line_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic serial_data_line_oe_out, direction_flag_out;
  logic ack_detected_flag_out, operation_enable_out;
  logic serial_clock_line_in, sda_low;
  int mismatches = 0, total_checks = 0;
  // pulled-up data line seen by both parties
  wire serial_data_line_in =
    !(sda_low | (serial_data_line_oe_out & !serial_data_line_out));
  ids_top u_dut (.*);
  ids_bus_peer u_peer (.scl_out(serial_clock_line_in), .sda_low_out(sda_low));
  always #4 clk_in = !clk_in;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // every wait is bounded; running out ends the run
  task automatic hop(inout int n);
    @(posedge clk_in);
    n++;
    if (n > 40) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic gap();
    repeat (8) @(posedge clk_in);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    while (aw || w) begin
      hop(n);
      if (aw && s_axi_awready_out) begin
        aw = 1'b0;
        s_axi_awvalid_in <= 1'b0;
      end
      if (w && s_axi_wready_out) begin
        w = 1'b0;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do hop(n); while (s_axi_bvalid_out !== 1'b1);
    chk(s_axi_bresp_out, er);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do hop(n); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do hop(n); while (s_axi_rvalid_out !== 1'b1);
    chk(s_axi_rdata_out, ed);
    chk(s_axi_rresp_out, er);
  endtask
  task automatic sgen();
    @(posedge clk_in);
    start_generated_in <= 1'b1;
    @(posedge clk_in);
    start_generated_in <= 1'b0;
    gap();
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    // ----
    // registers
    // ----
    axi_rd(`IDS_STAT_ADDR, 32'h0, `IDS_RESP_OKAY);
    axi_rd(4'h8, 32'h0, `IDS_RESP_SLVERR);
    axi_wr(4'hc, 32'h80, `IDS_RESP_SLVERR);
    axi_wr(`IDS_STAT_ADDR, 32'hff, `IDS_RESP_OKAY);
    axi_rd(`IDS_STAT_ADDR, 32'h0, `IDS_RESP_OKAY);
    axi_rd(`IDS_CTRL_ADDR, 32'h0, `IDS_RESP_OKAY);
    axi_wr(`IDS_CTRL_ADDR, 32'he0, `IDS_RESP_OKAY);
    axi_rd(`IDS_CTRL_ADDR, 32'h80, `IDS_RESP_OKAY);
    chk(operation_enable_out, 1'b1);
    // ----
    // slave addressed for reading, then wait cancel
    // ----
    u_peer.start_cond();
    u_peer.byte_out(8'ha5, 1'b1);
    gap();
    axi_rd(`IDS_STAT_ADDR, 32'hc, `IDS_RESP_OKAY);
    chk(serial_data_line_oe_out, 1'b1);
    serial_output_latch_in <= 1'b1;
    gap();
    chk(serial_data_line_oe_out, 1'b0);
    serial_output_latch_in <= 1'b0;
    gap();
    axi_wr(`IDS_CTRL_ADDR, 32'ha0, `IDS_RESP_OKAY);
    gap();
    axi_rd(`IDS_STAT_ADDR, 32'h4, `IDS_RESP_OKAY);
    chk(serial_data_line_oe_out, 1'b0);
    u_peer.bit_out(1'b1);
    gap();
    chk(ack_detected_flag_out, 1'b0);
    u_peer.stop_cond();
    // ----
    // slave repeated start, lsb 0, stop clears ack
    // ----
    @(posedge clk_in);
    serial_output_latch_in <= 1'b1;
    u_peer.start_cond();
    u_peer.byte_out(8'ha5, 1'b1);
    gap();
    chk(direction_flag_out, 1'b1);
    u_peer.start_cond();
    gap();
    chk(direction_flag_out, 1'b0);
    u_peer.byte_out(8'ha4, 1'b1);
    gap();
    chk({direction_flag_out, ack_detected_flag_out}, 2'b01);
    u_peer.stop_cond();
    gap();
    chk(ack_detected_flag_out, 1'b0);
    // ----
    // master role
    // ----
    master_role_in <= 1'b1;
    sgen();
    chk(direction_flag_out, 1'b1);
    arbitration_loss_flag_in <= 1'b1;
    gap();
    chk(direction_flag_out, 1'b0);
    arbitration_loss_flag_in <= 1'b0;
    sgen();
    axi_wr(`IDS_CTRL_ADDR, 32'hc0, `IDS_RESP_OKAY);
    gap();
    chk(direction_flag_out, 1'b0);
    sgen();
    axi_wr(`IDS_CTRL_ADDR, 32'h0, `IDS_RESP_OKAY);
    gap();
    chk(direction_flag_out, 1'b0);
    axi_wr(`IDS_CTRL_ADDR, 32'h80, `IDS_RESP_OKAY);
    u_peer.start_cond();
    sgen();
    u_peer.byte_out(8'ha5, 1'b0);
    gap();
    chk({direction_flag_out, ack_detected_flag_out}, 2'b00);
    u_peer.start_cond();
    sgen();
    u_peer.byte_out(8'ha4, 1'b0);
    gap();
    chk(direction_flag_out, 1'b1);
    u_peer.stop_cond();
    gap();
    chk(direction_flag_out, 1'b0);
    // ----
    // low enable freezes state: a start pulse is not taken
    // ----
    ce_in <= 1'b0;
    sgen();
    ce_in <= 1'b1;
    gap();
    chk(direction_flag_out, 1'b0);
    wrap_up();
  end
endmodule // testbench
